// [bench/single_wire_attention_and_ack_handler_tb_top.sv]
// Bench: controller end and sensor end on one wire, a second sensor end
// driven bit by bit from here. Assumes rtl/ is on the include path.
`timescale 1ns/1ps
`default_nettype none
module single_wire_attention_and_ack_handler_tb_top;
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, cd = 0, mon = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rs = 32'h4c1fd5eb;
  logic [9:0] cdat = 0;
  logic pready, pslverr, att, run, lp, be, run2, lp2, be2;
  logic [32:0] q[$];
  int error_cnt = 0, compares = 0;
  swl_link_if lk();
  swl_link_if l2();
  always #25 sys_clk = ~sys_clk;
  swl_mst_end i_swl_mst_end (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .link(lk.mst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .attention(att));
  swl_dev_end i_swl_dev_end (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .link(lk.dev),
    .dev_addr(2'h0), .conv_done(cd), .conv_data(cdat), .conv_run(run), .low_power(lp),
    .bus_error(be));
  swl_dev_end i_swl_dev_end_b (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1),
    .link(l2.dev), .dev_addr(2'h0), .conv_done(cd), .conv_data(cdat), .conv_run(run2),
    .low_power(lp2), .bus_error(be2));
  swl_sva i_swl_sva (.sys_clk(sys_clk), .rst_b(rst_b), .dev_oe(lk.dev_oe),
    .dev_do(lk.dev_do), .mst_oe(lk.mst_oe), .mst_do(lk.mst_do), .line(lk.line));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  task automatic chk(string n, logic [32:0] e, logic [32:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // ==========================================================================
  // APB master and controller orders
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rd(logic [7:0] a, logic [32:0] e);
    q.push_back(e);
    mon <= 1;
    apb(0, a, 0);
    mon <= 0;
  endtask : rd
  task automatic order(logic [15:0] c, logic [15:0] d);
    apb(1, 8'h00, {16'h0, c});
    apb(1, 8'h04, {16'h0, d});
    apb(1, 8'h08, 32'h1);
    do apb(0, 8'h0c, 0); while (prdata[0] !== 1'b0);
  endtask : order
  always @(posedge sys_clk)
    if (mon && psel && penable && !pwrite && pready) chk("apb read", q.pop_front(), {pslverr, prdata});
  // ==========================================================================
  // Bench-driven controller on the second wire
  task automatic sym(int n);
    l2.mst_oe <= 1;
    repeat (n) @(posedge sys_clk);
    l2.mst_oe <= 0;
    do @(posedge sys_clk); while (l2.line !== 1'b1);
    repeat (160) @(posedge sys_clk);
  endtask : sym
  task automatic frm(logic [26:0] b, logic p, int nb);
    sym(1120);
    for (int i = 26; i >= 27 - nb; i--) sym(b[i] ? 480 : 160);
    if (nb == 27) sym(p ? 480 : 160);
    if (nb == 27) sym(160);
  endtask : frm
  initial begin
    repeat (110000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    int n;
    logic [9:0] d;
    l2.mst_oe <= 1'b0;
    l2.mst_do <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1;
    repeat (10) @(posedge sys_clk);
    rd(8'h14, {1'b1, 32'h0});
    order(16'h0a00, 16'h0003);
    rd(8'h0c, 33'h2);
    order(16'h0500, 16'h0012);
    chk("conv_run", 0, run);
    order(16'h0500, 16'h0010);
    chk("conv_run", 1, run);
    for (int k = 0; k < 2; k++) begin
      d = 10'(rnd());
      @(posedge sys_clk) cd <= 1;
      cdat <= d;
      @(posedge sys_clk) cd <= 0;
      repeat (3000) @(posedge sys_clk);
      chk("attention", k == 0, att);
      apb(1, 8'h0c, 32'h8);
    end
    order(16'h0404, 16'h0);
    rd(8'h10, 33'h11);
    order(16'h0904, 16'h0);
    rd(8'h10, {17'h0, d, 6'h0});
    $display("controller tests done");
    frm(27'h050004, 0, 5);
    frm(27'h050004, 1, 27);
    sym(480);
    sym(480);
    chk("low_power", 1, lp2);
    chk("bus_error", 0, be2);
    frm(27'h050000, 1, 27);
    chk("low_power", 1, lp2);
    chk("bus_error", 1, be2);
    n = 0;
    repeat (1000) if (l2.dev_oe !== 1'b1) @(posedge sys_clk);
    while (l2.dev_oe === 1'b1 && n < 3000) begin
      n++;
      @(posedge sys_clk);
    end
    chk("error attention", 2400, n);
    $display("link fault tests done");
    report_and_stop();
  end
endmodule : single_wire_attention_and_ack_handler_tb_top
`default_nettype wire

// [bench/swl_sva.sv]
// Checker of the open-drain wire between the controller and sensor ends.
// Assumes the bench wires it to the link interface beside both ends.
`timescale 1ns/1ps
`default_nettype none
module swl_sva (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic dev_oe,
  input wire logic dev_do,
  input wire logic mst_oe,
  input wire logic mst_do,
  input wire logic line
);
  int dn;
  int mn;
  int hn;
  // ==========================================================================
  // Low and high time counters
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dn <= 0;
      mn <= 0;
      hn <= 4095;
    end else begin
      dn <= dev_oe ? dn + 1 : 0;
      mn <= mst_oe ? mn + 1 : 0;
      hn <= line ? hn + 1 : 0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_idle_rise;
    $rose(dev_oe) && $past(line);
  endsequence
  sequence s_hold;
    dev_oe [*8];
  endsequence
  a_drain_only: assert property (!dev_do && !mst_do) else $error("end drives high");
  a_dev_len: assert property ($fell(dev_oe) |-> dn == 480 || dn == 2400)
    else $error("sensor low time wrong");
  a_att_max: assert property (dn <= 2400) else $error("sensor holds too long");
  a_mst_len: assert property ($fell(mst_oe) |-> mn inside {160, 480, 1120, 4000})
    else $error("controller low time wrong");
  a_mst_gap: assert property ($rose(mst_oe) |-> hn >= 160) else $error("gap short");
  a_dev_joins: assert property ($rose(dev_oe) && !$past(line) |-> mst_oe)
    else $error("sensor stretch outside slot");
  a_att_idle: assert property (s_idle_rise |-> hn >= 480) else $error("bus not idle");
  a_att_hold: assert property (s_idle_rise |-> s_hold) else $error("attention cut");
endmodule : swl_sva
`default_nettype wire

// [rtl/swl_dev_end.sv]
// Sensor end of the link: symbol decode, frame tracking, parity and
// acknowledge, attention requests, status and control flags.
// Assumes the conversion engine outside pulses conv_done with conv_data.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "swl_map.svh"
module swl_dev_end (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  swl_link_if.dev         link,
  input  wire logic [1:0] dev_addr,
  input  wire logic       conv_done,
  input  wire logic [9:0] conv_data,
  output logic            conv_run,
  output logic            low_power,
  output logic            bus_error
);

  swl_pkg::swl_dev_t r;
  swl_pkg::swl_dev_t n;
  swl_pkg::swl_sym_t sym;
  logic              fall;
  logic              rise;
  logic              bit_v;
  logic              idle;
  logic              want;
  logic              nack;
  logic              commit_w;
  logic              commit_r;
  logic [7:0]        reg_ix;
  logic [15:0]       rd_val;

  // Register defaults as a named word so single bits can be picked out
  localparam logic [15:0] reg_rst = `SWL_REG_RESET;

  // ========================================================================
  // Next state
  always_comb begin
    n        = r;
    sym      = swl_pkg::swl_classify(r.lcnt);
    fall     = r.s3 & ~r.s2;
    rise     = ~r.s3 & r.s2;
    bit_v    = (sym == swl_pkg::SYM_ONE);
    idle     = (r.hcnt >= swl_pkg::swl_cnt_t'(`SWL_N_IDLE));
    want     = 1'b0;
    nack     = 1'b0;
    commit_w = 1'b0;
    commit_r = 1'b0;
    reg_ix   = {r.sh[6:0], bit_v};

    // Readable view of the registers for a read frame
    rd_val = '0;
    case (reg_ix)
      `SWL_REG_STATUS: begin
        rd_val[`SWL_ST_BUSERR]  = r.bus_error_flag;
        rd_val[`SWL_ST_OVERRUN] = r.overrun_flag;
        rd_val[`SWL_ST_DONE]    = r.conversion_done_flag;
      end
      `SWL_REG_DEVCTRL: begin
        rd_val[`SWL_DC_FEN]  = r.function_enable;
        rd_val[`SWL_DC_LOWP] = r.low_power;
        rd_val[`SWL_DC_SHUT] = r.shutdown;
      end
      `SWL_REG_READOUT: begin
        rd_val[15:`SWL_RO_LSB] = r.readout;
      end
      `SWL_REG_TEMPCTRL: begin
        rd_val[`SWL_TC_SEN]   = r.sensor_enable;
        rd_val[`SWL_TC_ATTEN] = r.attention_enable;
      end
      default: rd_val = '0;
    endcase

    // ======================================================================
    // Line sampling and pulse timing
    n.s1 = link.line;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (!r.s2) begin
      if (r.lcnt != '1) n.lcnt = r.lcnt + 13'h0001;
      n.hcnt = '0;
    end else begin
      n.lcnt = '0;
      if (r.hcnt != '1) n.hcnt = r.hcnt + 13'h0001;
    end

    // ======================================================================
    // Own drive: bit stretch or attention pulse
    if (r.drv) begin
      n.dcnt = r.dcnt + 13'h0001;
      if (r.drv_att) begin
        if (r.dcnt == swl_pkg::swl_len(swl_pkg::SYM_ATT) - 13'h0001) n.drv = 1'b0;
      end else begin
        if (r.dcnt == swl_pkg::swl_len(swl_pkg::SYM_ONE) - 13'h0001) n.drv = 1'b0;
      end
    end

    if (r.conv_pend && r.att_seen) n.conv_pend = 1'b0;

    if (r.st == swl_pkg::D_FRAME && r.idx > 5'(`SWL_IX_RW)) begin
      if (r.rw && r.idx > 5'(`SWL_IX_HDR_END) && r.idx <= 5'(`SWL_IX_PAR))
        want = r.tx[16];
      else if (!r.rw && r.idx == 5'(`SWL_IX_ACK))
        want = ~r.par;
    end

    if (!r.drv && ((r.err_pend && (idle || fall)) ||
        (r.conv_pend && idle && !r.att_seen &&
         r.attention_enable && r.sensor_enable))) begin
      n.drv       = 1'b1;
      n.drv_att   = 1'b1;
      n.dcnt      = '0;
      n.err_pend  = 1'b0;
      n.conv_pend = 1'b0;
    end else if (!r.drv && fall && want) begin
      n.drv     = 1'b1;
      n.drv_att = 1'b0;
      n.dcnt    = '0;
    end

    // ======================================================================
    // Symbol decode at the end of each low pulse
    if (rise) begin
      unique case (sym)
        swl_pkg::SYM_RESET: begin
          n.st       = swl_pkg::D_IDLE;
          n.att_seen = 1'b0;
        end
        swl_pkg::SYM_ATT: begin
          n.st       = swl_pkg::D_IDLE;
          n.att_seen = 1'b1;
        end
        swl_pkg::SYM_START: begin
          n.st  = swl_pkg::D_FRAME;
          n.idx = '0;
          n.par = 1'b0;
        end
        swl_pkg::SYM_ZERO, swl_pkg::SYM_ONE: begin
          if (r.st == swl_pkg::D_FRAME) begin
            n.idx = r.idx + 5'h01;
            if (r.idx <= 5'(`SWL_IX_PAR)) n.par = r.par ^ bit_v;
            if (r.idx < 5'(`SWL_IX_PAR)) n.sh = {r.sh[25:0], bit_v};
            if (r.idx == 5'(`SWL_IX_ADDR_END) && {r.sh[0], bit_v} != dev_addr)
              n.st = swl_pkg::D_SKIP;
            if (r.idx == 5'(`SWL_IX_RW)) n.rw = bit_v;
            if (r.idx == 5'(`SWL_IX_HDR_END))
              n.tx = {rd_val, r.par ^ bit_v ^ (^rd_val)};
            else if (r.idx > 5'(`SWL_IX_HDR_END))
              n.tx = {r.tx[15:0], 1'b0};
            if (r.idx == 5'(`SWL_IX_ACK)) begin
              n.st = swl_pkg::D_SKIP;
              if (!bit_v) nack = 1'b1;
              else if (!r.rw) commit_w = 1'b1;
              else commit_r = 1'b1;
            end
          end
        end
      endcase
    end

    // ======================================================================
    // Effects of completed frames
    if (commit_w) begin
      case (r.sh[23:16])
        `SWL_REG_DEVCTRL: begin
          n.function_enable = r.sh[`SWL_DC_FEN];
          n.low_power       = r.sh[`SWL_DC_LOWP];
          n.shutdown        = r.sh[`SWL_DC_SHUT];
          if (r.sh[`SWL_DC_RST]) begin
            n.function_enable      = reg_rst[`SWL_DC_FEN];
            n.low_power            = reg_rst[`SWL_DC_LOWP];
            n.shutdown             = reg_rst[`SWL_DC_SHUT];
            n.attention_enable     = reg_rst[`SWL_TC_ATTEN];
            n.sensor_enable        = reg_rst[`SWL_TC_SEN];
            n.bus_error_flag       = 1'b0;
            n.overrun_flag         = 1'b0;
            n.conversion_done_flag = 1'b0;
            n.readout              = '0;
            n.conv_pend            = 1'b0;
            n.err_pend             = 1'b0;
          end
        end
        `SWL_REG_TEMPCTRL: begin
          n.sensor_enable    = r.sh[`SWL_TC_SEN];
          n.attention_enable = r.sh[`SWL_TC_ATTEN];
        end
        default: n.readout = r.readout;
      endcase
    end

    if (commit_r) begin
      case (r.sh[23:16])
        `SWL_REG_STATUS: begin
          n.bus_error_flag = 1'b0;
          n.att_seen       = 1'b0;
        end
        `SWL_REG_READOUT: begin
          n.conversion_done_flag = 1'b0;
          n.overrun_flag         = 1'b0;
          n.conv_pend            = 1'b0;
        end
        default: n.readout = r.readout;
      endcase
    end

    // Sets come last so they win over clears in the same cycle
    if (conv_done && conv_run) begin
      if (r.conversion_done_flag) n.overrun_flag = 1'b1;
      n.conversion_done_flag = 1'b1;
      n.readout              = conv_data;
      if (r.attention_enable && r.sensor_enable && !r.att_seen)
        n.conv_pend = 1'b1;
    end

    if (nack) begin
      n.bus_error_flag = 1'b1;
      n.err_pend       = 1'b1;
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else if (clk_en) begin
      r <= n;
    end
  end

  // ========================================================================
  // Outputs
  assign link.dev_oe = r.drv;
  assign link.dev_do = 1'b0;
  assign conv_run    = r.function_enable & r.sensor_enable & ~r.shutdown;
  assign low_power   = r.low_power;
  assign bus_error   = r.bus_error_flag;

endmodule : swl_dev_end
`default_nettype wire

// [rtl/swl_link_if.sv]
// Open-drain data wire shared by the sensor end and the controller end.
// Assumes an external pull-up: the wire is high unless an end drives it.
`timescale 1ns/1ps
`default_nettype none
interface swl_link_if;
  logic dev_oe;
  logic dev_do;
  logic mst_oe;
  logic mst_do;
  logic line;

  assign line = (~dev_oe | dev_do) & (~mst_oe | mst_do);

  modport dev (input line, output dev_oe, output dev_do);
  modport mst (input line, output mst_oe, output mst_do);
endinterface : swl_link_if
`default_nettype wire

// [rtl/swl_map.svh]
// Constants of the single-wire attention and acknowledge link: symbol times,
// frame layout, sensor register indices and bit positions, controller map.
// Assumes both ends run on a 20 MHz sys_clk.
`ifndef SWL_MAP_SVH
`define SWL_MAP_SVH

// ==========================================================================
// Symbol timing
`define SWL_CLK_MHZ      20
`define SWL_T_ZERO_NS    8000
`define SWL_T_ONE_NS     24000
`define SWL_T_START_NS   56000
`define SWL_T_ATT_NS     120000
`define SWL_T_RST_NS     200000
`define SWL_T_GAP_NS     8000
`define SWL_T_IDLE_NS    24000
`define SWL_CYC(ns)      (((ns) * `SWL_CLK_MHZ) / 1000)
`define SWL_N_ZERO       `SWL_CYC(`SWL_T_ZERO_NS)
`define SWL_N_ONE        `SWL_CYC(`SWL_T_ONE_NS)
`define SWL_N_START      `SWL_CYC(`SWL_T_START_NS)
`define SWL_N_ATT        `SWL_CYC(`SWL_T_ATT_NS)
`define SWL_N_RST        `SWL_CYC(`SWL_T_RST_NS)
`define SWL_N_GAP        `SWL_CYC(`SWL_T_GAP_NS)
`define SWL_N_IDLE       `SWL_CYC(`SWL_T_IDLE_NS)
`define SWL_TH_01        ((`SWL_N_ZERO + `SWL_N_ONE) / 2)
`define SWL_TH_1S        ((`SWL_N_ONE + `SWL_N_START) / 2)
`define SWL_TH_SA        ((`SWL_N_START + `SWL_N_ATT) / 2)
`define SWL_TH_AR        ((`SWL_N_ATT + `SWL_N_RST) / 2)

// ==========================================================================
// Frame layout: addr[1:0], rw, reg[7:0], data[15:0], parity, acknowledge
`define SWL_IX_ADDR_END  1
`define SWL_IX_RW        2
`define SWL_IX_HDR_END   10
`define SWL_IX_PAR       27
`define SWL_IX_ACK       28

// ==========================================================================
// Sensor registers
`define SWL_REG_STATUS   8'h04
`define SWL_REG_DEVCTRL  8'h05
`define SWL_REG_READOUT  8'h09
`define SWL_REG_TEMPCTRL 8'h0a
`define SWL_ST_BUSERR    7
`define SWL_ST_OVERRUN   4
`define SWL_ST_DONE      0
`define SWL_DC_FEN       4
`define SWL_DC_LOWP      2
`define SWL_DC_SHUT      1
`define SWL_DC_RST       0
`define SWL_TC_SEN       1
`define SWL_TC_ATTEN     0
`define SWL_RO_LSB       6
`define SWL_REG_RESET    16'h0000

// ==========================================================================
// Controller APB map
`define SWL_A_CMD        8'h00
`define SWL_A_WDATA      8'h04
`define SWL_A_CTRL       8'h08
`define SWL_A_STAT       8'h0c
`define SWL_A_RDATA      8'h10
`define SWL_CT_GO        0
`define SWL_CT_BUSRST    1
`define SWL_MS_BUSY      0
`define SWL_MS_OK        1
`define SWL_MS_NACK      2
`define SWL_MS_ATT       3
`define SWL_MS_ABORT     4

`endif

// [rtl/swl_mst_end.sv]
// Controller end of the link: runs one frame or a bus reset on order from
// APB registers, drives the acknowledge of reads, watches for attention.
// Assumes an APB master on the same sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "swl_map.svh"
module swl_mst_end (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  swl_link_if.mst          link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             attention
);

  swl_pkg::swl_mst_t r;
  swl_pkg::swl_mst_t n;
  swl_pkg::swl_sym_t sym;
  swl_pkg::swl_cnt_t len;
  logic              b;
  logic              mdrv;
  logic              im;
  logic              wr;
  logic              hit;

  always_comb begin
    n    = r;
    sym  = swl_pkg::swl_classify(r.cnt);
    b    = (sym == swl_pkg::SYM_ONE);
    // Write ack slot belongs to the sensor: pull only a zero and let it stretch
    mdrv = r.rw ? ((r.idx <= 5'(`SWL_IX_HDR_END)) | (r.idx == 5'(`SWL_IX_ACK)))
                : (r.idx != 5'(`SWL_IX_ACK));
    im   = (r.idx == 5'(`SWL_IX_ACK)) ? (~r.par & ~r.conflict) : r.txs[27];
    hit  = (paddr == `SWL_A_CMD) || (paddr == `SWL_A_WDATA) || (paddr == `SWL_A_CTRL) ||
           (paddr == `SWL_A_STAT) || (paddr == `SWL_A_RDATA);
    wr   = psel & penable & pwrite;
    if (r.bus_rst) len = swl_pkg::swl_len(swl_pkg::SYM_RESET);
    else if (r.in_start) len = swl_pkg::swl_len(swl_pkg::SYM_START);
    else if (mdrv && im) len = swl_pkg::swl_len(swl_pkg::SYM_ONE);
    else len = swl_pkg::swl_len(swl_pkg::SYM_ZERO);

    n.s1 = link.line;
    n.s2 = r.s1;

    // ======================================================================
    // APB registers
    if (psel && !penable) begin
      n.prdata = '0;
      case (paddr)
        `SWL_A_CMD:   n.prdata = {16'h0000, r.regi, 5'h00, r.rw, r.dev};
        `SWL_A_WDATA: n.prdata = {16'h0000, r.wdata};
        `SWL_A_STAT:  n.prdata = {27'h0000000, r.abort, r.att, r.nack, r.ok, r.busy};
        `SWL_A_RDATA: n.prdata = {16'h0000, r.rdata};
        default:      n.prdata = '0;
      endcase
    end
    if (wr && !r.busy) begin
      case (paddr)
        `SWL_A_CMD: begin
          n.dev  = pwdata[1:0];
          n.rw   = pwdata[2];
          n.regi = pwdata[15:8];
        end
        `SWL_A_WDATA: n.wdata = pwdata[15:0];
        `SWL_A_CTRL: begin
          if (r.st == swl_pkg::M_IDLE && (pwdata[`SWL_CT_GO] || pwdata[`SWL_CT_BUSRST])) begin
            n.st       = swl_pkg::M_DRIVE;
            n.cnt      = '0;
            n.busy     = 1'b1;
            n.bus_rst  = pwdata[`SWL_CT_BUSRST];
            n.in_start = ~pwdata[`SWL_CT_BUSRST];
            n.idx      = '0;
            n.par      = 1'b0;
            n.conflict = 1'b0;
            n.ok       = 1'b0;
            n.nack     = 1'b0;
            n.abort    = 1'b0;
            n.txs      = {r.dev, r.rw, r.regi, r.wdata, ^{r.dev, r.rw, r.regi, r.wdata}};
          end
        end
        default: n.rdata = r.rdata;
      endcase
    end
    if (wr && paddr == `SWL_A_STAT && pwdata[`SWL_MS_ATT]) n.att = 1'b0;

    // ======================================================================
    // Link sequencer
    unique case (r.st)
      swl_pkg::M_IDLE: begin
        if (!r.s2 && n.st == swl_pkg::M_IDLE) begin
          n.st  = swl_pkg::M_OBS;
          n.cnt = '0;
        end
      end
      swl_pkg::M_OBS: begin
        if (r.cnt != '1) n.cnt = r.cnt + 13'h0001;
        if (r.s2) begin
          if (sym == swl_pkg::SYM_ATT) n.att = 1'b1;
          n.st = swl_pkg::M_IDLE;
        end
      end
      swl_pkg::M_DRIVE: begin
        n.cnt = r.cnt + 13'h0001;
        if (r.cnt == len - 13'h0001) n.st = swl_pkg::M_REL;
      end
      swl_pkg::M_REL: begin
        if (r.cnt != '1) n.cnt = r.cnt + 13'h0001;
        if (r.s2) begin
          n.st  = swl_pkg::M_GAP;
          n.cnt = '0;
          if (r.bus_rst) begin
            n.bus_rst = 1'b0;
            n.fin     = 1'b1;
          end else if (sym == swl_pkg::SYM_ATT) begin
            n.att   = 1'b1;
            n.abort = 1'b1;
            n.fin   = 1'b1;
          end else if (r.in_start) begin
            n.in_start = 1'b0;
          end else begin
            if (mdrv && b != im) n.conflict = 1'b1;
            if (r.idx <= 5'(`SWL_IX_PAR)) n.par = r.par ^ b;
            if (r.idx > 5'(`SWL_IX_HDR_END) && r.idx < 5'(`SWL_IX_PAR))
              n.rxd = {r.rxd[14:0], b};
            n.txs = {r.txs[26:0], 1'b0};
            n.idx = r.idx + 5'h01;
            if (r.idx == 5'(`SWL_IX_ACK)) begin
              n.fin  = 1'b1;
              n.ok   = b;
              n.nack = ~b;
              if (b && r.rw) n.rdata = r.rxd;
            end
          end
        end
      end
      swl_pkg::M_GAP: begin
        n.cnt = r.cnt + 13'h0001;
        if (!r.s2) begin
          n.st    = swl_pkg::M_OBS;
          n.cnt   = '0;
          n.busy  = 1'b0;
          n.fin   = 1'b0;
          n.abort = ~r.fin;
        end else if (r.cnt == swl_pkg::swl_cnt_t'(`SWL_N_GAP) - 13'h0001) begin
          n.cnt = '0;
          n.st  = r.fin ? swl_pkg::M_IDLE : swl_pkg::M_DRIVE;
          n.busy = ~r.fin;
          n.fin  = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign link.mst_oe = (r.st == swl_pkg::M_DRIVE);
  assign link.mst_do = 1'b0;
  assign prdata      = r.prdata;
  assign pready      = 1'b1;
  assign pslverr     = psel & penable & ~hit;
  assign attention   = r.att;

endmodule : swl_mst_end
`default_nettype wire

// [rtl/swl_pkg.sv]
// Types shared by both ends of the single-wire link.
// Assumes swl_map.svh supplies the timing macros.
`include "swl_map.svh"
package swl_pkg;

  typedef logic [12:0] swl_cnt_t;
  typedef enum logic [2:0] {SYM_ZERO, SYM_ONE, SYM_START, SYM_ATT, SYM_RESET} swl_sym_t;
  typedef enum logic [1:0] {D_IDLE, D_FRAME, D_SKIP} swl_dev_st_t;
  typedef enum logic [2:0] {M_IDLE, M_DRIVE, M_REL, M_GAP, M_OBS} swl_mst_st_t;

  typedef struct packed {
    logic        s1, s2, s3;
    swl_dev_st_t st;
    swl_cnt_t    lcnt, hcnt, dcnt;
    logic        drv, drv_att, rw, par;
    logic [4:0]  idx;
    logic [26:0] sh;
    logic [16:0] tx;
    logic        bus_error_flag, overrun_flag, conversion_done_flag;
    logic        attention_enable, sensor_enable, function_enable;
    logic        shutdown, low_power;
    logic [9:0]  readout;
    logic        att_seen, err_pend, conv_pend;
  } swl_dev_t;

  typedef struct packed {
    logic        s1, s2;
    swl_mst_st_t st;
    swl_cnt_t    cnt;
    logic        in_start, bus_rst, fin, rw, par, conflict;
    logic [4:0]  idx;
    logic [27:0] txs;
    logic [15:0] rxd, rdata, wdata;
    logic [1:0]  dev;
    logic [7:0]  regi;
    logic        busy, ok, nack, att, abort;
    logic [31:0] prdata;
  } swl_mst_t;

  // Symbol from measured low time
  function automatic swl_sym_t swl_classify(input swl_cnt_t n);
    swl_sym_t s;
    if (n < swl_cnt_t'(`SWL_TH_01)) s = SYM_ZERO;
    else if (n < swl_cnt_t'(`SWL_TH_1S)) s = SYM_ONE;
    else if (n < swl_cnt_t'(`SWL_TH_SA)) s = SYM_START;
    else if (n < swl_cnt_t'(`SWL_TH_AR)) s = SYM_ATT;
    else s = SYM_RESET;
    return s;
  endfunction : swl_classify

  // Low time a party drives for a symbol
  function automatic swl_cnt_t swl_len(input swl_sym_t s);
    swl_cnt_t v;
    case (s)
      SYM_ONE:   v = swl_cnt_t'(`SWL_N_ONE);
      SYM_START: v = swl_cnt_t'(`SWL_N_START);
      SYM_ATT:   v = swl_cnt_t'(`SWL_N_ATT);
      SYM_RESET: v = swl_cnt_t'(`SWL_N_RST);
      default:   v = swl_cnt_t'(`SWL_N_ZERO);
    endcase
    return v;
  endfunction : swl_len

endpackage : swl_pkg
